// file: rtl/asd_pkg.sv
// shared constants and types for the axi slave slot decoder
package asd_pkg;
   // ************************************************
   // fixed widths
   // ************************************************
   localparam int ADDR_W = 32;
   localparam int TAG_W = 4;
   localparam int PORT_TAG_EXTRA = 2;
   localparam int PORT_TAG_W = TAG_W + PORT_TAG_EXTRA;
   localparam int NUM_SLOTS = 16;
   localparam int NUM_PORTS = 17;
   localparam int PORT_W = 5;
   localparam logic [4:0] PORT_EXTRA = 5'h10;
   localparam int SLOT_SHIFT_TOP = 32;
   localparam int SLOT_SHIFT_STEP = 4;
   localparam int HUGE_INDEX_BITS = 3;
   localparam int SLOT_INDEX_BITS = 4;
   localparam int HUGE_SEL_BIT = 31;

   // ************************************************
   // response codes
   // ************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_EXOKAY = 2'h1;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ************************************************
   // register map
   // ************************************************
   localparam logic [11:0] REG_CONTROL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_BLOCKED = 12'h008;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam int STAT_DECERR_BIT = 0;
   localparam int STAT_PORT_LSB = 8;
   localparam int STAT_OK_BIT = 16;
   localparam int BLOCKED_W = 16;

   typedef struct packed {
      logic ok;
      logic [4:0] port;
   } asd_route_type;
endpackage : asd_pkg

// file: rtl/asd_slot_decoder.sv
// address slot decoder and connectivity gate for a multi-master axi3 interconnect
`timescale 1ns/1ps
// Overview of operation
// - memory space 1 splits the 4 GB range into 16 slots of 256 MB.
// - memory space 2..6 gives 16 slots of 16 MB, 1 MB, 64 KB, 4 KB, 256 B.
// - memory space 0 gives one 2 GB half to the huge slave, other half 8 slots.
// - huge layout 1..6 sizes the 8 slots 256 MB down to 256 B, only in space 0.
// - huge placement 0 puts the huge slave where address bit 31 is low.
// - huge placement 1, the default, puts it at 0x80000000, bit 31 high.
// - combine flags act only when memory space is above zero.
// - a combined slot goes out on port 16 and its own port is unavailable.
// - an uncombined slot keeps its own port, available if enabled.
// - each master to port pair has an enable; only master 0 to port 0 by default.
// - space 0 with placement 0 makes ports 0 to 7 unavailable.
// - space 0 with placement 1 ignores the enable of port 16 and makes ports 8 to 15 unavailable.
// - one to four masters, default one.
// - data bus 64, 128 or 256 bits, default 64; address fixed at 32 bits.
// - master tags are 4 bits; port tags carry 2 extra bits.
// - responses 00 okay, 01 exokay, 10 slverr, 11 decerr; a decode error sets a sticky status flag.
// - one write strobe per byte lane; strobe n covers data bits 8n+7..8n.
// - the 4-bit burst length passes to the slave unchanged.
// - only the burst start address goes to the slave.
// - space 0 with huge half high routes every bit 31 set access to port 16.
// - 8 slots of 256 MB are chosen by address bits 30..28.
module asd_slot_decoder #(
   parameter int NUM_MASTERS = 1,
   parameter int DATA_W = 64,
   parameter int MEM_SPACE = 1,
   parameter int HUGE_SIZE = 1,
   parameter bit HUGE_PLACE = 1'b1,
   parameter logic [15:0] COMBINE = 16'h0000,
   parameter logic [67:0] PATH_EN = 68'h1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // address requests from the masters
   input wire logic [NUM_MASTERS-1:0] req_valid,
   output logic [NUM_MASTERS-1:0] req_ready,
   input wire logic [NUM_MASTERS-1:0] req_write,
   input wire logic [NUM_MASTERS-1:0][31:0] req_addr,
   input wire logic [NUM_MASTERS-1:0][3:0] req_tag,
   input wire logic [NUM_MASTERS-1:0][3:0] req_len,
   input wire logic [NUM_MASTERS-1:0][2:0] req_size,
   // routed requests toward the slave ports
   output logic [NUM_MASTERS-1:0] route_valid,
   input wire logic [NUM_MASTERS-1:0] route_ready,
   output logic [NUM_MASTERS-1:0] route_ok,
   output logic [NUM_MASTERS-1:0][4:0] route_port,
   output logic [NUM_MASTERS-1:0] route_write,
   output logic [NUM_MASTERS-1:0][31:0] route_addr,
   output logic [NUM_MASTERS-1:0][5:0] route_tag,
   output logic [NUM_MASTERS-1:0][3:0] route_len,
   output logic [NUM_MASTERS-1:0][2:0] route_size,
   output logic [NUM_MASTERS-1:0][DATA_W/8-1:0] route_strb,
   // responses coming back from the slave ports
   input wire logic rsp_valid,
   input wire logic [1:0] rsp_code
);
   localparam int LANES = DATA_W / 8;
   localparam int LANE_W = $clog2(LANES);

   // ************************************************
   // configuration checks
   // ************************************************
   if (NUM_MASTERS < 1 || NUM_MASTERS > 4) begin : g_bad_masters
      $error("master count must be 1 to 4");
   end
   if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256) begin : g_bad_width
      $error("data width must be 64, 128 or 256");
   end
   if (MEM_SPACE < 0 || MEM_SPACE > 6 || HUGE_SIZE < 1 || HUGE_SIZE > 6) begin : g_bad_space
      $error("memory space or huge layout out of range");
   end

   // ************************************************
   // decoding functions
   // ************************************************
   // is a slave port reachable at all in this layout
   function automatic logic port_avail(input logic [4:0] p);
      logic r;
      r = 1'b1;
      if (MEM_SPACE == 0) begin
         if (!HUGE_PLACE && p < 5'h8) begin
            r = 1'b0;
         end
         if (HUGE_PLACE && (p == 5'hf || (p > 5'h7 && p < 5'h10))) begin
            r = 1'b0;
         end
      end else if (p == asd_pkg::PORT_EXTRA) begin
         r = |COMBINE;
      end else begin
         r = !COMBINE[p[3:0]];
      end
      return r;
   endfunction : port_avail

   // is master m allowed onto port p
   function automatic logic path_on(input int m, input logic [4:0] p);
      logic r;
      r = PATH_EN[m * asd_pkg::NUM_PORTS + int'(p)];
      if (MEM_SPACE == 0 && HUGE_PLACE && p == asd_pkg::PORT_EXTRA) begin
         r = 1'b1;
      end
      return r;
   endfunction : path_on

   function automatic asd_pkg::asd_route_type decode(input int m, input logic [31:0] a);
      asd_pkg::asd_route_type r;
      int sh;
      logic [3:0] slot;
      logic inrange;
      r = '0;
      inrange = 1'b1;
      slot = 4'h0;
      if (MEM_SPACE == 0) begin
         sh = asd_pkg::SLOT_SHIFT_TOP - asd_pkg::SLOT_SHIFT_STEP * HUGE_SIZE;
         if (a[asd_pkg::HUGE_SEL_BIT] == HUGE_PLACE) begin
            r.port = asd_pkg::PORT_EXTRA;
         end else begin
            slot = {a[asd_pkg::HUGE_SEL_BIT], 3'(a >> sh)};
            inrange = ({1'b0, a[30:0]} >> (sh + asd_pkg::HUGE_INDEX_BITS)) == 32'h0;
            r.port = {1'b0, slot};
         end
      end else begin
         sh = asd_pkg::SLOT_SHIFT_TOP - asd_pkg::SLOT_SHIFT_STEP * MEM_SPACE;
         slot = 4'(a >> sh);
         inrange = (sh + asd_pkg::SLOT_INDEX_BITS >= asd_pkg::ADDR_W) ||
                   ((a >> (sh + asd_pkg::SLOT_INDEX_BITS)) == 32'h0);
         r.port = COMBINE[slot] ? asd_pkg::PORT_EXTRA : {1'b0, slot};
      end
      r.ok = inrange && port_avail(r.port) && path_on(m, r.port);
      return r;
   endfunction : decode

   // first beat byte lanes from start address and size
   function automatic logic [LANES-1:0] lanes_of(input logic [31:0] a, input logic [2:0] sz);
      logic [LANES-1:0] m;
      int n;
      int lo;
      n = 1 << sz;
      lo = int'(a[LANE_W-1:0]) & ~(n - 1);
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         if (i >= lo && i < lo + n) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : lanes_of

   // ************************************************
   // control register
   // ************************************************
   logic route_enable;
   logic decerr_seen;
   logic [4:0] last_port;
   logic last_ok;
   logic [asd_pkg::BLOCKED_W-1:0] blocked_count;
   logic apb_wr;
   logic apb_setup;
   logic decerr_clear;
   logic [NUM_MASTERS-1:0] take;

   assign apb_wr = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   assign decerr_clear = apb_wr && paddr[11:0] == asd_pkg::REG_STATUS && pwdata[asd_pkg::STAT_DECERR_BIT];
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_enable <= asd_pkg::CTRL_ENABLE_RESET;
      end else if (apb_wr && paddr[11:0] == asd_pkg::REG_CONTROL) begin
         route_enable <= pwdata[asd_pkg::CTRL_ENABLE_BIT];
      end
   end

   // ************************************************
   // status: decode error sticky, last route, blocked count
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decerr_seen <= 1'b0;
      end else if (rsp_valid && rsp_code == asd_pkg::RESP_DECERR) begin
         decerr_seen <= 1'b1;
      end else if (decerr_clear) begin
         decerr_seen <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_port <= 5'h0;
         last_ok <= 1'b0;
      end else begin
         for (int m = NUM_MASTERS - 1; m >= 0; m--) begin
            if (take[m]) begin
               last_port <= decode(m, req_addr[m]).port;
               last_ok <= decode(m, req_addr[m]).ok;
            end
         end
      end
   end

   logic blocked_now;
   always_comb begin
      blocked_now = 1'b0;
      for (int m = 0; m < NUM_MASTERS; m++) begin
         if (take[m] && !decode(m, req_addr[m]).ok) begin
            blocked_now = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocked_count <= '0;
      end else if (blocked_now && blocked_count != '1) begin
         blocked_count <= blocked_count + 1'b1;
      end else if (!blocked_now && apb_wr && paddr[11:0] == asd_pkg::REG_BLOCKED) begin
         blocked_count <= '0;
      end
   end

   // ************************************************
   // apb read path
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (apb_setup && !pwrite) begin
         prdata <= 32'h0;
         case (paddr[11:0])
            asd_pkg::REG_CONTROL: prdata[asd_pkg::CTRL_ENABLE_BIT] <= route_enable;
            asd_pkg::REG_STATUS: begin
               prdata[asd_pkg::STAT_DECERR_BIT] <= decerr_seen;
               prdata[asd_pkg::STAT_PORT_LSB +: 5] <= last_port;
               prdata[asd_pkg::STAT_OK_BIT] <= last_ok;
            end
            asd_pkg::REG_BLOCKED: prdata[asd_pkg::BLOCKED_W-1:0] <= blocked_count;
            default: prdata <= 32'h0;
         endcase
      end
   end

   always_comb begin
      case (paddr[11:0])
         asd_pkg::REG_CONTROL, asd_pkg::REG_STATUS, asd_pkg::REG_BLOCKED: pslverr = 1'b0;
         default: pslverr = psel && penable;
      endcase
   end

   // ************************************************
   // per master route stage
   // ************************************************
   for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_mst
      assign req_ready[m] = route_enable && (!route_valid[m] || route_ready[m]);
      assign take[m] = req_valid[m] && req_ready[m];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            route_valid[m] <= 1'b0;
         end else if (take[m]) begin
            route_valid[m] <= 1'b1;
         end else if (route_ready[m]) begin
            route_valid[m] <= 1'b0;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            route_ok[m] <= 1'b0;
            route_port[m] <= 5'h0;
            route_write[m] <= 1'b0;
            route_addr[m] <= 32'h0;
            route_tag[m] <= 6'h0;
            route_len[m] <= 4'h0;
            route_size[m] <= 3'h0;
            route_strb[m] <= '0;
         end else if (take[m]) begin
            route_ok[m] <= decode(m, req_addr[m]).ok;
            route_port[m] <= decode(m, req_addr[m]).port;
            route_write[m] <= req_write[m];
            route_addr[m] <= req_addr[m];
            route_tag[m] <= {2'(m), req_tag[m]};
            route_len[m] <= req_len[m];
            route_size[m] <= req_size[m];
            route_strb[m] <= req_write[m] ? lanes_of(req_addr[m], req_size[m]) : '0;
         end
      end

      // ************************************************
      // checks
      // ************************************************
      a_hold_stall: assert property (@(posedge pclk) disable iff (!presetn)
         route_valid[m] && !route_ready[m] |=> route_valid[m] && $stable(route_addr[m]) && $stable(route_port[m]))
         else $error("routed request changed while stalled");
      a_tag_widened: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] |=> route_tag[m] == {2'(m), $past(req_tag[m])})
         else $error("port tag not master index over master tag");
      a_len_passed: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] |=> route_len[m] == $past(req_len[m]) && route_valid[m])
         else $error("burst length altered");
      a_start_addr: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] |=> route_addr[m] == $past(req_addr[m]))
         else $error("start address altered");
      a_huge_route: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] && MEM_SPACE == 0 && HUGE_PLACE && req_addr[m][31] |=> route_port[m] == 5'h10 && route_ok[m])
         else $error("upper half not routed to port 16");
      a_combine_route: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] && MEM_SPACE > 0 && COMBINE[4'(req_addr[m] >> (32 - 4 * MEM_SPACE))] &&
         (32 - 4 * MEM_SPACE + 4 >= 32 || (req_addr[m] >> (36 - 4 * MEM_SPACE)) == 0)
         |=> route_port[m] == 5'h10)
         else $error("combined slot not sent to port 16");
      a_path_block: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] && !path_on(m, decode(m, req_addr[m]).port) |=> !route_ok[m])
         else $error("disabled path let through");
      a_strb_write: assert property (@(posedge pclk) disable iff (!presetn)
         take[m] && req_write[m] |=> $countones(route_strb[m]) == ((1 << route_size[m]) < LANES ?
            (1 << route_size[m]) : LANES))
         else $error("strobe count does not match size");
      c_routed: cover property (@(posedge pclk) disable iff (!presetn) take[m] ##1 route_ok[m]);
      c_blocked: cover property (@(posedge pclk) disable iff (!presetn) take[m] ##1 !route_ok[m]);
      c_stall: cover property (@(posedge pclk) disable iff (!presetn)
         route_valid[m] && !route_ready[m] ##1 route_ready[m]);
   end

   a_decerr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      rsp_valid && rsp_code == asd_pkg::RESP_DECERR |=> decerr_seen ##1 (decerr_seen || $past(decerr_clear)))
      else $error("decode error flag not held");
   c_decerr: cover property (@(posedge pclk) disable iff (!presetn) rsp_valid && rsp_code == 2'h3);
endmodule : asd_slot_decoder

// file: verification/asd_far_model.sv
// far-side model of the slave ports: accepts routed requests and answers them
`timescale 1ns/1ps
module asd_far_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // routed requests
   input wire logic [1:0] route_valid,
   output logic [1:0] route_ready,
   input wire logic [1:0][5:0] route_tag,
   // responses
   output logic rsp_valid,
   output logic [1:0] rsp_code,
   output logic [5:0] rsp_tag,
   // scenario control
   input wire logic slow,
   input wire logic bad
);
   logic [1:0] pace;
   logic [1:0] seq;
   // ************************************************
   // acceptance: prompt, or one cycle in four when slow
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace <= 2'h0;
         route_ready <= 2'h0;
      end else begin
         pace <= pace + 2'h1;
         route_ready <= (slow && pace != 2'h2) ? 2'h0 : 2'h3;
      end
   end
   // ************************************************
   // responses: legal codes in turn, a decode error only when told
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid <= 1'b0;
         rsp_code <= 2'h0;
         rsp_tag <= 6'h0;
         seq <= 2'h0;
      end else if (|(route_valid & route_ready)) begin
         rsp_valid <= 1'b1;
         // write response and read data both carry the accepted request's tag
         for (int k = 1; k >= 0; k--) begin
            if (route_valid[k] && route_ready[k]) begin
               rsp_tag <= route_tag[k];
            end
         end
         rsp_code <= bad ? asd_pkg::RESP_DECERR : seq;
         seq <= (seq == 2'h2) ? 2'h0 : seq + 2'h1;
      end else begin
         rsp_valid <= 1'b0;
         // released code lines do not keep the last value
         rsp_code <= ~rsp_code;
         rsp_tag <= ~rsp_tag;
      end
   end
endmodule : asd_far_model

// file: verification/tb_asd_slot_decoder.sv
// self-checking bench for the axi slave slot decoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_asd_slot_decoder;
   localparam logic [15:0] COMB = 16'h0004;
   localparam logic [67:0] PEN1 = 68'h41000d;
   localparam logic [67:0] PEN2 = 68'h8009;
   // master, write, size, address
   localparam logic [43:0] CASES [10] = '{44'h0_1_3_00000010, 44'h0_1_2_2abc0004, 44'h0_0_1_30000006,
      44'h0_1_0_50000003, 44'h1_1_0_51234567, 44'h1_1_1_00000002, 44'h1_0_2_20000000, 44'h0_1_3_f0000000,
      44'h1_0_3_90000000, 44'h0_1_2_3ffffffc};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] req_valid = 2'h0;
   logic [1:0] req_write = 2'h0;
   logic [1:0][31:0] req_addr = '0;
   logic [1:0][3:0] req_tag = '0;
   logic [1:0][3:0] req_len = '0;
   logic [1:0][2:0] req_size = '0;
   logic [1:0] req_ready, route_valid, route_ready, route_ok, route_write, ok2;
   logic [1:0][4:0] route_port, port2;
   logic [1:0][31:0] route_addr;
   logic [1:0][5:0] route_tag;
   logic [1:0][3:0] route_len;
   logic [1:0][7:0] route_strb;
   logic [1:0][2:0] route_size;
   logic rsp_valid;
   logic [1:0] rsp_code;
   logic [5:0] rsp_tag;
   logic slow = 1'b0;
   logic bad = 1'b0;
   int fail_count = 0;
   int checked = 0;
   logic [31:0] q;
   logic e;
   always #4 pclk = ~pclk;
   // ************************************************
   // design instances and far side
   // ************************************************
   asd_slot_decoder #(.NUM_MASTERS(2), .COMBINE(COMB), .PATH_EN(PEN1)) u_asd_slot_decoder (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_tag(req_tag), .req_len(req_len), .req_size(req_size),
      .route_valid(route_valid), .route_ready(route_ready), .route_ok(route_ok), .route_port(route_port),
      .route_write(route_write), .route_addr(route_addr), .route_tag(route_tag), .route_len(route_len),
      .route_size(route_size), .route_strb(route_strb), .rsp_valid(rsp_valid), .rsp_code(rsp_code));
   // huge layout, huge half high; accepts at once
   asd_slot_decoder #(.NUM_MASTERS(2), .MEM_SPACE(0), .PATH_EN(PEN2)) u_asd_slot_decoder_huge (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .req_valid(req_valid), .req_ready(), .req_write(req_write),
      .req_addr(req_addr), .req_tag(req_tag), .req_len(req_len), .req_size(req_size), .route_valid(),
      .route_ready(2'h3), .route_ok(ok2), .route_port(port2), .route_write(), .route_addr(), .route_tag(),
      .route_len(), .route_size(), .route_strb(), .rsp_valid(rsp_valid), .rsp_code(rsp_code));
   asd_far_model u_asd_far_model (.pclk(pclk), .presetn(presetn), .route_valid(route_valid),
      .route_ready(route_ready), .route_tag(route_tag), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
      .rsp_tag(rsp_tag), .slow(slow), .bad(bad));
   // ************************************************
   // expectations and shared tasks
   // ************************************************
   function automatic logic [5:0] exp1(input int m, input logic [31:0] a);
      logic [4:0] p;
      p = COMB[a[31:28]] ? 5'h10 : {1'b0, a[31:28]};
      return {PEN1[m*17+p], p};
   endfunction : exp1
   function automatic logic [5:0] exp2(input int m, input logic [31:0] a);
      logic [4:0] p;
      p = a[31] ? 5'h10 : {1'b0, a[31:28]};
      return {a[31] | PEN2[m*17+p], p};
   endfunction : exp2
   function automatic logic [7:0] exp_strb(input logic w, input logic [2:0] s, input logic [2:0] lo);
      logic [2:0] base;
      base = lo & ~((3'h1 << s) - 3'h1);
      return w ? (((8'h1 << (4'h1 << s)) - 8'h1) << base) : 8'h0;
   endfunction : exp_strb
   task automatic conclude();
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin fail_count++; conclude(); end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic send(input int m, input logic w, input logic [31:0] a, input logic [3:0] t, input logic [3:0] l,
      input logic [2:0] s);
      logic [5:0] e1;
      logic [5:0] e2;
      int n;
      e1 = exp1(m, a);
      e2 = exp2(m, a);
      @(posedge pclk);
      req_valid[m] <= 1'b1;
      req_write[m] <= w;
      req_addr[m] <= a;
      req_tag[m] <= t;
      req_len[m] <= l;
      req_size[m] <= s;
      n = 0;
      do begin @(posedge pclk); n++; end while (req_ready[m] !== 1'b1 && n < 40);
      if (req_ready[m] !== 1'b1) begin fail_count++; conclude(); end
      req_valid[m] <= 1'b0;
      @(posedge pclk);
      `CHK("huge ok", e2[5], ok2[m])
      if (e2[5]) `CHK("huge port", e2[4:0], port2[m])
      n = 0;
      while (!(route_valid[m] === 1'b1 && route_ready[m] === 1'b1) && n < 40) begin @(posedge pclk); n++; end
      if (!(route_valid[m] === 1'b1 && route_ready[m] === 1'b1)) begin fail_count++; conclude(); end
      `CHK("ok", e1[5], route_ok[m])
      if (e1[5]) `CHK("port", e1[4:0], route_port[m])
      `CHK("tag", {m[1:0], t}, route_tag[m])
      `CHK("len", l, route_len[m])
      `CHK("addr", a, route_addr[m])
      `CHK("write", w, route_write[m])
      `CHK("strb", exp_strb(w, s, a[2:0]), route_strb[m])
      `CHK("size", s, route_size[m])
      @(posedge pclk);
      `CHK("response tag", {m[1:0], t}, rsp_tag)
   endtask : send
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_regs();
      apb(1'b0, asd_pkg::REG_CONTROL, 32'h0);
      `CHK("control reset", 32'h1, q)
      apb(1'b1, 12'h00c, 32'hffffffff);
      `CHK("unmapped write err", 1'b1, e)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped read err", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
   endtask : t_regs
   task automatic t_routes();
      for (int i = 0; i < 10; i++) begin
         slow <= i[0];
         send(int'(CASES[i][43:40]), CASES[i][36], CASES[i][31:0], i[3:0], 4'(15 - i), CASES[i][34:32]);
      end
      slow <= 1'b0;
      apb(1'b0, asd_pkg::REG_STATUS, 32'h0);
      `CHK("last port", 5'h03, q[12:8])
      `CHK("last ok", 1'b1, q[16])
      `CHK("no decode error", 1'b0, q[0])
      apb(1'b0, asd_pkg::REG_BLOCKED, 32'h0);
      `CHK("blocked count", 32'h5, q)
      apb(1'b1, asd_pkg::REG_BLOCKED, 32'h0);
      apb(1'b0, asd_pkg::REG_BLOCKED, 32'h0);
      `CHK("blocked cleared", 32'h0, q)
   endtask : t_routes
   task automatic t_disable();
      apb(1'b1, asd_pkg::REG_CONTROL, 32'h0);
      @(posedge pclk);
      req_valid[0] <= 1'b1;
      repeat (3) begin
         @(negedge pclk);
         `CHK("ready while off", 1'b0, req_ready[0])
      end
      `CHK("no route while off", 1'b0, route_valid[0])
      @(posedge pclk);
      req_valid[0] <= 1'b0;
      apb(1'b1, asd_pkg::REG_CONTROL, 32'h1);
   endtask : t_disable
   task automatic t_resp();
      bad <= 1'b1;
      send(0, 1'b1, 32'h00000020, 4'h9, 4'h0, 3'h3);
      bad <= 1'b0;
      apb(1'b0, asd_pkg::REG_STATUS, 32'h0);
      `CHK("decode error seen", 1'b1, q[0])
      apb(1'b1, asd_pkg::REG_STATUS, 32'h1);
      apb(1'b0, asd_pkg::REG_STATUS, 32'h0);
      `CHK("decode error cleared", 1'b0, q[0])
   endtask : t_resp
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_routes();
      t_disable();
      t_resp();
      conclude();
   end
endmodule : tb_asd_slot_decoder
